// *** logic/ssprx_top.sv ***
// Synchronous serial port with APB registers, master/slave shift engine and receive FIFO
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssprx_defines.svh"

module ssprx_top (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire ssprx_pkg::ssprx_word_t pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output ssprx_pkg::ssprx_word_t  prdata,
    input  wire logic               serialDataIn,
    output logic                    serialDataOut,
    output logic                    serialDataOe,
    input  wire logic               serialClockIn,
    output logic                    serialClockOut,
    output logic                    serialClockOe
);
    import ssprx_pkg::*;

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    ssprx_byte_t  irqEnable;
    ssprx_byte_t  baudDivisor;
    ssprx_byte_t  txHold;
    logic         txFull;
    logic         portEnable, rxNine, singleRx, contRx, addrDetect;
    logic         master, txNine, txEnable, syncMode, highSpeed, txNinth;
    logic         overrun, overrunSingle;
    ssprx_char_t  fifoMem [2];
    logic         fifoHead;
    logic [1:0]   fifoCount;
    ssprx_state_e state;
    ssprx_char_t  shiftReg;
    logic [3:0]   bitCount;
    logic [9:0]   baudCount;
    logic         dataSync1, dataSync2, clkSync1, clkSync2, clkPrev;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wrAcc, rdAcc, setup, mapped, popReq;
    assign setup  = psel & ~penable;
    assign wrAcc  = psel & penable & pwrite;
    assign rdAcc  = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb begin
        case (paddr)
            `SSPRX_ADDR_IRQ_ENABLE, `SSPRX_ADDR_IRQ_FLAGS, `SSPRX_ADDR_RX_STATUS,
            `SSPRX_ADDR_BAUD_DIV, `SSPRX_ADDR_TX_DATA, `SSPRX_ADDR_TX_STATUS,
            `SSPRX_ADDR_RX_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;
    // Reading the data register advances the FIFO
    assign popReq = rdAcc & (paddr == `SSPRX_ADDR_RX_DATA) & (fifoCount != 2'd0);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic active, txMode, rxGo, lead, trail, halfTick, lastBit, charDone;
    logic [3:0] charBits;
    ssprx_char_t rxChar;
    assign active   = portEnable & syncMode;
    assign txMode   = active & ~singleRx & ~contRx & txEnable;
    // Slave ignores the single enable
    assign rxGo     = active & ~overrun & (master ? (singleRx | contRx) : contRx);
    assign charBits = rxNine ? `SSPRX_BITS_NINE : `SSPRX_BITS_EIGHT;
    assign lastBit  = (bitCount == charBits - 4'd1);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dataSync1 <= 1'b0;
            dataSync2 <= 1'b0;
            clkSync1  <= 1'b0;
            clkSync2  <= 1'b0;
            clkPrev   <= 1'b0;
        end else begin
            dataSync1 <= serialDataIn;
            dataSync2 <= dataSync1;
            clkSync1  <= serialClockIn;
            clkSync2  <= clkSync1;
            clkPrev   <= clkSync2;
        end
    end

    // ----------------------------------------------------------------
    // Baud generator, half shift-clock period
    // ----------------------------------------------------------------
    logic [9:0] baudReload;
    assign baudReload = highSpeed ? {2'b00, baudDivisor}
                        : (({2'b00, baudDivisor} + 10'd1) << `SSPRX_LOW_SPEED_SHIFT) - 10'd1;
    assign halfTick   = (baudCount == 10'd0);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state == SSPRX_IDLE || !master) begin
            baudCount <= baudReload;
        end else if (halfTick) begin
            baudCount <= baudReload;
        end else begin
            baudCount <= baudCount - 10'd1;
        end
    end

    // Leading edge rises, trailing edge falls; clock idles low
    assign lead  = master ? (state != SSPRX_IDLE) & halfTick & ~serialClockOut
                          : clkSync2 & ~clkPrev;
    assign trail = master ? (state != SSPRX_IDLE) & halfTick & serialClockOut
                          : ~clkSync2 & clkPrev;
    assign rxChar   = rxNine ? {dataSync2, shiftReg[8:1]} : {1'b0, dataSync2, shiftReg[8:2]};
    assign charDone = (state == SSPRX_RX) & rxGo & trail & lastBit;

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !portEnable) begin
            state          <= SSPRX_IDLE;
            shiftReg       <= '0;
            bitCount       <= 4'd0;
            serialClockOut <= 1'b0;
            serialDataOut  <= 1'b0;
        end else begin
            case (state)
                SSPRX_IDLE: begin
                    serialClockOut <= 1'b0;
                    bitCount       <= 4'd0;
                    if (rxGo) begin
                        state <= SSPRX_RX;
                    end else if (txMode && txFull) begin
                        shiftReg <= {txNinth, txHold};
                        state    <= SSPRX_TX;
                    end
                end
                SSPRX_RX: begin
                    if (!rxGo) begin
                        // Partial character is dropped and clock parks low
                        state          <= SSPRX_IDLE;
                        serialClockOut <= 1'b0;
                    end else begin
                        if (master && halfTick) begin
                            serialClockOut <= ~serialClockOut;
                        end
                        if (trail) begin
                            shiftReg <= {dataSync2, shiftReg[8:1]};
                            bitCount <= lastBit ? 4'd0 : bitCount + 4'd1;
                        end
                    end
                end
                SSPRX_TX: begin
                    if (!txMode) begin
                        state          <= SSPRX_IDLE;
                        serialClockOut <= 1'b0;
                    end else begin
                        if (master && halfTick) begin
                            serialClockOut <= ~serialClockOut;
                        end
                        if (lead) begin
                            serialDataOut <= shiftReg[0];
                            shiftReg      <= {1'b0, shiftReg[8:1]};
                        end
                        if (trail) begin
                            bitCount <= bitCount + 4'd1;
                            if ((bitCount == (txNine ? `SSPRX_BITS_NINE : `SSPRX_BITS_EIGHT) - 4'd1)) begin
                                state <= SSPRX_IDLE;
                            end
                        end
                    end
                end
                default: state <= SSPRX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    assign serialClockOe = active & master;
    assign serialDataOe  = txMode;

    // ----------------------------------------------------------------
    // Receive FIFO and overrun
    // ----------------------------------------------------------------
    logic pushOk;
    assign pushOk = charDone & (fifoCount != `SSPRX_FIFO_DEPTH);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !portEnable) begin
            fifoHead   <= 1'b0;
            fifoCount  <= 2'd0;
            fifoMem[0] <= '0;
            fifoMem[1] <= '0;
        end else begin
            if (pushOk) begin
                fifoMem[fifoHead ^ fifoCount[0]] <= rxChar;
            end
            if (popReq) begin
                fifoHead <= ~fifoHead;
            end
            fifoCount <= fifoCount + {1'b0, pushOk} - {1'b0, popReq};
        end
    end

    // Set wins over any clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !portEnable) begin
            overrun       <= 1'b0;
            overrunSingle <= 1'b0;
        end else if (charDone && fifoCount == `SSPRX_FIFO_DEPTH) begin
            overrun       <= 1'b1;
            overrunSingle <= master & singleRx & ~contRx;
        end else if (overrunSingle ? popReq : ~contRx) begin
            overrun <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {portEnable, rxNine, singleRx, contRx, addrDetect} <= 5'b00000;
        end else if (wrAcc && paddr == `SSPRX_ADDR_RX_STATUS) begin
            portEnable <= pwdata[`SSPRX_RS_PORT_EN];
            rxNine     <= pwdata[`SSPRX_RS_RX_NINE];
            singleRx   <= pwdata[`SSPRX_RS_SINGLE_RX];
            contRx     <= pwdata[`SSPRX_RS_CONT_RX];
            addrDetect <= pwdata[`SSPRX_RS_ADDR_DET];
        end else if (!portEnable) begin
            singleRx <= 1'b0;
        end else if (charDone && master) begin
            singleRx <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {master, txNine, txEnable, syncMode, highSpeed, txNinth} <= 6'b000000;
            irqEnable   <= `SSPRX_RST_BYTE;
            baudDivisor <= `SSPRX_RST_BYTE;
        end else if (wrAcc) begin
            case (paddr)
                `SSPRX_ADDR_TX_STATUS: begin
                    master    <= pwdata[`SSPRX_TS_MASTER];
                    txNine    <= pwdata[`SSPRX_TS_TX_NINE];
                    txEnable  <= pwdata[`SSPRX_TS_TX_EN];
                    syncMode  <= pwdata[`SSPRX_TS_SYNC];
                    highSpeed <= pwdata[`SSPRX_TS_HIGH_SPEED];
                    txNinth   <= pwdata[`SSPRX_TS_TX_NINTH];
                end
                `SSPRX_ADDR_IRQ_ENABLE: irqEnable <= pwdata[7:0];
                `SSPRX_ADDR_BAUD_DIV:   baudDivisor <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Holding register is freed when the engine takes it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txHold <= `SSPRX_RST_BYTE;
            txFull <= 1'b0;
        end else begin
            if (wrAcc && paddr == `SSPRX_ADDR_TX_DATA) begin
                txHold <= pwdata[7:0];
                txFull <= 1'b1;
            end else if (!portEnable || (state == SSPRX_IDLE && !rxGo && txMode && txFull)) begin
                txFull <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------------------------------
    ssprx_char_t top;
    ssprx_byte_t readByte;
    assign top = fifoMem[fifoHead];
    always_comb begin
        case (paddr)
            `SSPRX_ADDR_IRQ_ENABLE: readByte = irqEnable;
            `SSPRX_ADDR_IRQ_FLAGS:  readByte = {2'b00, fifoCount != 2'd0, ~txFull, 4'h0};
            `SSPRX_ADDR_RX_STATUS:  readByte = {portEnable, rxNine, singleRx, contRx, addrDetect,
                                                1'b0, overrun, top[8]};
            `SSPRX_ADDR_BAUD_DIV:   readByte = baudDivisor;
            `SSPRX_ADDR_TX_STATUS:  readByte = {master, txNine, txEnable, syncMode, 1'b0,
                                                highSpeed, state != SSPRX_TX, txNinth};
            `SSPRX_ADDR_RX_DATA:    readByte = top[7:0];
            default:                readByte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= {24'h00_0000, readByte};
        end
    end
endmodule
`default_nettype wire

// *** logic/ssprx_defines.svh ***
// Register map, field positions, reset values and widths of the synchronous serial port
`ifndef SSPRX_DEFINES_SVH
`define SSPRX_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSPRX_ADDR_IRQ_ENABLE   8'h00
`define SSPRX_ADDR_IRQ_FLAGS    8'h04
`define SSPRX_ADDR_RX_STATUS    8'h08
`define SSPRX_ADDR_BAUD_DIV     8'h0C
`define SSPRX_ADDR_TX_DATA      8'h10
`define SSPRX_ADDR_TX_STATUS    8'h14
`define SSPRX_ADDR_RX_DATA      8'h18
// ----------------------------------------------------------------
// receive_status_control fields
// ----------------------------------------------------------------
`define SSPRX_RS_PORT_EN        7
`define SSPRX_RS_RX_NINE        6
`define SSPRX_RS_SINGLE_RX      5
`define SSPRX_RS_CONT_RX        4
`define SSPRX_RS_ADDR_DET       3
`define SSPRX_RS_FRAMING        2
`define SSPRX_RS_OVERRUN        1
`define SSPRX_RS_RX_NINTH       0
// ----------------------------------------------------------------
// transmit_status_control fields
// ----------------------------------------------------------------
`define SSPRX_TS_MASTER         7
`define SSPRX_TS_TX_NINE        6
`define SSPRX_TS_TX_EN          5
`define SSPRX_TS_SYNC           4
`define SSPRX_TS_HIGH_SPEED     2
`define SSPRX_TS_SHIFT_EMPTY    1
`define SSPRX_TS_TX_NINTH       0
// ----------------------------------------------------------------
// peripheral_irq_flags / enable fields
// ----------------------------------------------------------------
`define SSPRX_IRQ_RX            5
`define SSPRX_IRQ_TX            4
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SSPRX_RST_TX_STATUS     8'h02
`define SSPRX_RST_BYTE          8'h00
`define SSPRX_FIFO_DEPTH        2'd2
`define SSPRX_BITS_EIGHT        4'd8
`define SSPRX_BITS_NINE         4'd9
`define SSPRX_LOW_SPEED_SHIFT   2
`endif

// *** logic/ssprx_pkg.sv ***
// Types shared by the synchronous serial port
package ssprx_pkg;
    typedef enum logic [2:0] {
        SSPRX_IDLE = 3'b001,
        SSPRX_TX   = 3'b010,
        SSPRX_RX   = 3'b100
    } ssprx_state_e;
    typedef logic [7:0]  ssprx_byte_t;
    typedef logic [8:0]  ssprx_char_t;
    typedef logic [31:0] ssprx_word_t;
endpackage

// *** tb/ssprx_top_properties.sv ***
// Concurrent checks on the serial port pins and APB answers
`timescale 1ns/1ps
`default_nettype none
`include "ssprx_defines.svh"
module ssprx_top_properties (
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire ssprx_pkg::ssprx_word_t pwdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire ssprx_pkg::ssprx_word_t prdata,
    input wire logic                   serialDataIn,
    input wire logic                   serialDataOut,
    input wire logic                   serialDataOe,
    input wire logic                   serialClockIn,
    input wire logic                   serialClockOut,
    input wire logic                   serialClockOe
);
    import ssprx_pkg::*;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------
    // Shadows of written control bits
    // ------------------------------------------------
    logic [7:0]  rxCtl, txCtl, divisor, riseCnt;
    logic [10:0] hiCnt, halfPer;
    logic [2:0]  sinceWr;
    logic        wrDone, mapped, masterCfg, slaveCfg, rxOn, portOff;
    assign wrDone    = psel && penable && pwrite;
    assign mapped    = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    assign masterCfg = rxCtl[`SSPRX_RS_PORT_EN] && txCtl[`SSPRX_TS_SYNC] && txCtl[`SSPRX_TS_MASTER];
    assign slaveCfg  = rxCtl[`SSPRX_RS_PORT_EN] && txCtl[`SSPRX_TS_SYNC] && !txCtl[`SSPRX_TS_MASTER];
    assign rxOn      = masterCfg && rxCtl[`SSPRX_RS_CONT_RX];
    assign portOff   = !rxCtl[`SSPRX_RS_PORT_EN];
    assign halfPer   = (11'h001 + {3'h0, divisor}) << (txCtl[`SSPRX_TS_HIGH_SPEED] ? 2'h0 : 2'h2);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxCtl   <= 8'h00;
            txCtl   <= 8'h02;
            divisor <= 8'h00;
        end else if (wrDone) begin
            if (paddr == `SSPRX_ADDR_RX_STATUS) rxCtl <= pwdata[7:0];
            if (paddr == `SSPRX_ADDR_TX_STATUS) txCtl <= pwdata[7:0];
            if (paddr == `SSPRX_ADDR_BAUD_DIV) divisor <= pwdata[7:0];
        end
    end
    // Phases cut by software writes are left out of the period check
    always_ff @(posedge sys_clk) begin
        hiCnt   <= serialClockOut ? hiCnt + 11'h001 : 11'h000;
        sinceWr <= (sys_rst || wrDone) ? 3'h0 : sinceWr + {2'h0, sinceWr != 3'h7};
        riseCnt <= (sys_rst || (wrDone && paddr == `SSPRX_ADDR_RX_STATUS)) ? 8'h00
                   : riseCnt + {7'h00, $rose(serialClockOut)};
    end
    AST_RX_DATA_RELEASED: assert property (rxOn && $past(rxOn) |-> !serialDataOe)
        else $error("data pin driven during master receive");
    AST_SINGLE_CLOCKS: assert property (masterCfg && rxCtl[5] && !rxCtl[4] |-> riseCnt <= (rxCtl[6] ? 8'h09 : 8'h08))
        else $error("too many clocks for one character");
    AST_CLOCK_STOPS: assert property ($fell(rxCtl[4]) && !rxCtl[5] && masterCfg |-> ##2 (!serialClockOut) [*8])
        else $error("clock kept running after continuous receive cleared");
    AST_HALF_PERIOD: assert property ($fell(serialClockOut) && masterCfg && sinceWr == 3'h7 |-> hiCnt == halfPer)
        else $error("shift clock high phase off baud setting");
    AST_SLAVE_CLOCK_RELEASED: assert property (slaveCfg && $past(slaveCfg) |-> !serialClockOe)
        else $error("clock pin driven in slave mode");
    AST_MASTER_DRIVES_CLOCK: assert property (masterCfg && $past(masterCfg) |-> serialClockOe)
        else $error("clock pin not driven in master mode");
    AST_PORT_OFF_QUIET: assert property (portOff && $past(portOff) |-> !serialClockOe && !serialDataOe)
        else $error("pins driven while port disabled");
    AST_UNMAPPED_ERROR: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error does not match address map");
    AST_READ_ZERO: assert property (psel && !penable && !pwrite && (paddr == `SSPRX_ADDR_TX_DATA || !mapped)
        |=> prdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    cover property (masterCfg && $fell(serialClockOut));
    cover property (slaveCfg && $rose(serialClockIn));
    cover property (wrDone && paddr == `SSPRX_ADDR_TX_DATA);
endmodule
`default_nettype wire

// *** tb/ssprx_partner.sv ***
// Far serial device: data source, bit capture and link clock master
`timescale 1ns/1ps
`default_nettype none
module ssprx_partner (
    input  wire logic clockLine,
    input  wire logic dataLine,
    output var  logic dataDrive,
    output var  logic clockDrive
);
    logic [26:0] stream;
    logic [15:0] capture;
    int          total, idx, rises;
    initial begin
        {dataDrive, clockDrive, capture, total, idx, rises} = '0;
    end
    // New bit on leading edge; spent line toggles so no stale bit survives
    always @(posedge clockLine) begin
        rises     <= rises + 1;
        idx       <= idx + 1;
        dataDrive <= (idx < total) ? stream[idx] : !dataDrive;
    end
    always @(negedge clockLine) capture <= {dataLine, capture[15:1]};
    task automatic load(input logic [26:0] bits, input int n);
        stream = bits;
        total  = n;
        {idx, rises} = '0;
    endtask
    // Clock stands low between frames
    task automatic clockOut(input int n);
        repeat (n) begin
            #100 clockDrive = 1'b1;
            #100 clockDrive = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/tb_sync_serial_port_rx_path.sv ***
// Self-checking bench of the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssprx_defines.svh"
module tb_sync_serial_port_rx_path;
    import ssprx_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic wr; logic [7:0] e; logic err;} ssprx_row_s;
    localparam logic [7:0] AF = `SSPRX_ADDR_IRQ_FLAGS;
    localparam logic [7:0] RS = `SSPRX_ADDR_RX_STATUS;
    localparam logic [7:0] RD = `SSPRX_ADDR_RX_DATA;
    localparam logic [7:0] TS = `SSPRX_ADDR_TX_STATUS;
    localparam logic [7:0] TD = `SSPRX_ADDR_TX_DATA;
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, lastErr;
    logic        serialDataOut, serialDataOe, serialClockOut, serialClockOe;
    logic        dataLine, clockLine, dataDrive, clockDrive;
    logic [7:0]  paddr, d;
    ssprx_word_t pwdata, prdata;
    int          failures, compares, cycles, n;
    ssprx_row_s  rows [10];
    assign dataLine  = serialDataOe ? serialDataOut : dataDrive;
    assign clockLine = serialClockOe ? serialClockOut : clockDrive;
    ssprx_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .serialDataIn(dataLine), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .serialClockIn(clockLine), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe));
    ssprx_partner partner (.clockLine(clockLine), .dataLine(dataLine), .dataDrive(dataDrive), .clockDrive(clockDrive));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        int k = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h000000, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd      = prdata[7:0];
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wrR(input logic [7:0] a, input logic [7:0] v);
        xfer(1'b1, a, v, d);
    endtask
    task automatic rdCk(input logic [7:0] a, input string w, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, d);
        check(w, {8'h00, e}, {8'h00, d & m});
    endtask
    task automatic waitBit(input logic [7:0] a, input int b, input logic v);
        int k = 0;
        do begin
            xfer(1'b0, a, 8'h00, d);
            k++;
        end while (d[b] !== v && k < 300);
        check("awaited bit", {15'h0000, v}, {15'h0000, d[b]});
    endtask
    task automatic waitRises(input int r);
        for (int k = 0; partner.rises < r && k < 3000; k++) @(posedge sys_clk);
    endtask
    task automatic rxChar(input logic [7:0] c, input logic [26:0] s, input int nb, input int b, input logic v);
        partner.load(s, nb);
        wrR(RS, c);
        waitBit(RS, b, v);
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end
    // ------------------------------------------------
    // Register table, then receive and transmit cases
    // ------------------------------------------------
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata, failures, compares, cycles} = '0;
        sys_rst = 1'b1;
        rows = '{'{8'h00, 8'h00, 0, 8'h00, 0}, '{RS, 8'h00, 0, 8'h00, 0}, '{8'h0C, 8'h00, 0, 8'h00, 0},
                 '{TD, 8'h00, 0, 8'h00, 0}, '{TS, 8'h00, 0, 8'h02, 0}, '{RD, 8'h00, 0, 8'h00, 0},
                 '{8'h00, 8'h5A, 1, 8'h5A, 0}, '{RD, 8'h33, 1, 8'h00, 0}, '{8'h1C, 8'h44, 1, 8'h00, 1},
                 '{8'h0C, 8'h03, 1, 8'h03, 0}};
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rows[i]) begin
            if (rows[i].wr) wrR(rows[i].a, rows[i].w);
            rdCk(rows[i].a, "register", 8'hFF, rows[i].e);
            check("slave error", {15'h0000, rows[i].err}, {15'h0000, lastErr});
        end
        $display("test registers done");
        wrR(TS, 8'h94);
        wrR(RS, 8'h80);
        rxChar(8'hA0, 27'h00000A5, 8, 5, 1'b0);
        repeat (20) @(posedge sys_clk);
        check("clock count", 16'h0008, 16'(partner.rises));
        rdCk(AF, "rx flag", 8'h20, 8'h20);
        rdCk(RD, "rx data", 8'hFF, 8'hA5);
        rdCk(AF, "rx flag", 8'h20, 8'h00);
        rxChar(8'hE0, 27'h00001A5, 9, 5, 1'b0);
        rdCk(RS, "status", 8'hFF, 8'hC1);
        rdCk(RD, "rx data", 8'hFF, 8'hA5);
        check("clock count", 16'h0009, 16'(partner.rises));
        $display("test single receive done");
        partner.load(27'h00000FF, 8);
        wrR(RS, 8'h90);
        waitRises(4);
        wrR(RS, 8'h80);
        repeat (40) @(posedge sys_clk);
        check("clock count", 16'h0004, 16'(partner.rises));
        rdCk(AF, "rx flag", 8'h20, 8'h00);
        rxChar(8'hB0, {3'h0, 8'h5A, 8'hC3, 8'h3C}, 24, 1, 1'b1);
        rdCk(RS, "status", 8'hFF, 8'h92);
        n = partner.rises;
        repeat (60) @(posedge sys_clk);
        check("clock count", 16'(n), 16'(partner.rises));
        rdCk(RD, "rx data", 8'hFF, 8'h3C);
        rdCk(RS, "status", 8'hFF, 8'h92);
        rdCk(RD, "rx data", 8'hFF, 8'hC3);
        wrR(RS, 8'h80);
        rdCk(RS, "status", 8'hFF, 8'h80);
        $display("test continuous overrun done");
        for (int i = 1; i <= 3; i++) begin
            rxChar(8'hA0, 27'(8'h11 * i), 8, (i < 3) ? 5 : 1, i == 3);
        end
        rdCk(RD, "rx data", 8'hFF, 8'h11);
        rdCk(RS, "overrun", 8'h02, 8'h00);
        rdCk(AF, "rx flag", 8'h20, 8'h20);
        wrR(RS, 8'h00);
        rdCk(AF, "rx flag", 8'h20, 8'h00);
        $display("test single overrun done");
        wrR(RS, 8'h80);
        wrR(TS, 8'hB0);
        partner.load(27'h0000000, 0);
        wrR(TD, 8'h96);
        wrR(TD, 8'h69);
        waitRises(16);
        repeat (20) @(posedge sys_clk);
        rdCk(TS, "tx status", 8'hFF, 8'hB2);
        check("clock count", 16'h0010, 16'(partner.rises));
        check("tx bits", 16'h6996, partner.capture);
        $display("test transmit done");
        wrR(TS, 8'h10);
        wrR(RS, 8'h90);
        partner.load(27'h0000069, 8);
        #10 partner.clockOut(8);
        repeat (10) @(posedge sys_clk);
        rdCk(AF, "rx flag", 8'h20, 8'h20);
        rdCk(RD, "rx data", 8'hFF, 8'h69);
        $display("test slave receive done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdCk(TS, "reset tx status", 8'hFF, `SSPRX_RST_TX_STATUS);
        rdCk(AF, "reset flags", 8'hFF, 8'h10);
        $display("test reset done");
        finish_test;
    end
endmodule
bind ssprx_top ssprx_top_properties chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .serialClockIn(serialClockIn), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe));
`default_nettype wire
